// ### scd_smartcard_uart.sv
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module scd_smartcard_uart
(
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic [scd_pkg::ADDR_W-1:0]  paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        ioIn,
   output scd_pkg::scd_line_t               ioLine,
   output logic                             cardClk,
   output logic                             dmaTxReq,
   output logic                             irq
);
   import scd_pkg::*;

   logic [CFG_W-1:0] cfg_q;
   logic [7:0]       clkReg_q;
   logic [15:0]      bit_rate_divider_q;
   logic [15:0]      baudCnt_q;
   logic [31:0]      prdata_q;
   logic             pslverr_q;
   logic [4:0]       flags_q;
   logic             irq_q;
   logic             ackBit_q;
   logic             parBit_q;
   logic [7:0]       txData_q;
   logic             txPending_q;
   logic             retryLock_q;
   logic [3:0]       retryCnt_q;
   scd_state_t       state_q;
   scd_state_t       state_d;
   logic [3:0]       bitIdx_q;
   logic             ack1_q;
   logic             ack2_q;
   logic [7:0]       rxShift_q;
   logic [7:0]       rxData_q;
   logic             rxUnread_q;
   logic             perr_q;
   logic             nackDrv_q;
   logic             lineOe_q;

   // Bus decode
   wire setupPh   = psel & ~penable;
   wire accessPh  = psel & penable;
   wire wrAcc     = accessPh & pwrite;
   wire hitBaudLo = paddr == OFF_BAUD_LO;
   wire hitBaudHi = paddr == OFF_BAUD_HI;
   wire hitData   = paddr == OFF_DATA;
   wire hitInfo   = paddr == OFF_INFO;
   wire hitCfg    = paddr == OFF_CFG;
   wire hitClk    = paddr == OFF_CLK;
   wire mapped    = hitBaudLo | hitBaudHi | hitData | hitInfo | hitCfg | hitClk;
   wire wrBaudLo  = wrAcc & hitBaudLo;
   wire wrBaudHi  = wrAcc & hitBaudHi;
   wire wrData    = wrAcc & hitData;
   wire wrInfo    = wrAcc & hitInfo;
   wire wrCfg     = wrAcc & hitCfg;
   wire wrClk     = wrAcc & hitClk;
   wire rdData    = accessPh & ~pwrite & hitData;

   // Configuration fields
   wire       scEn      = cfg_q[CFG_EN];
   wire       parOdd    = cfg_q[CFG_PAR];
   wire       nackTwo   = cfg_q[CFG_NACK_LEN];
   wire       autoNack  = cfg_q[CFG_AUTO];
   wire       lsbFirst  = cfg_q[CFG_LSB];
   wire       ackOneBit = cfg_q[CFG_ACK_SEL];
   wire [3:0] retryLim  = cfg_q[CFG_RTY_LO +: 4];

   wire [31:0] infoWord = {23'h000000, flags_q[4], flags_q[3], flags_q[2], flags_q[1],
                           2'b00, flags_q[0], parBit_q, ackBit_q};

   wire [31:0] rdMux = ({32{hitBaudLo}} & {24'h000000, bit_rate_divider_q[7:0]})
                     | ({32{hitBaudHi}} & {24'h000000, bit_rate_divider_q[15:8]})
                     | ({32{hitData}}   & {24'h000000, rxData_q})
                     | ({32{hitInfo}}   & infoWord)
                     | ({32{hitCfg}}    & {15'h0000, cfg_q})
                     | ({32{hitClk}}    & {24'h000000, clkReg_q});

   // Bit timing: one overflow per bit, a half load for mid-bit sampling
   wire [16:0] period  = BAUD_SPAN - {1'b0, bit_rate_divider_q};
   wire [15:0] midLoad = bit_rate_divider_q + period[16:1];
   wire        tick    = baudCnt_q == BAUD_TOP;

   wire [2:0] pos  = 3'(bitIdx_q - 4'h1);
   wire [2:0] slot = lsbFirst ? pos : 3'h7 - pos;
   wire       txBit = txData_q[slot];
   wire       txPar = (^txData_q) ^ parOdd;
   wire       rxPar = (^rxShift_q) ^ parOdd;
   wire       inData = (bitIdx_q != BIT_START) && (bitIdx_q <= BIT_DLAST);

   // Transmit events
   wire txStart  = (state_q == ST_IDLE) & scEn & txPending_q & ~retryLock_q;
   wire txTick   = (state_q == ST_TX) & tick;
   wire txEnd    = txTick & (bitIdx_q == BIT_WAIT);
   wire nack     = ~ack1_q & (ackOneBit | ~ack2_q);
   wire retryOut = retryCnt_q == retryLim;
   wire txFail   = txEnd & nack & retryOut;
   wire txOk     = txEnd & ~nack;
   wire txRetry  = txEnd & nack & ~retryOut;

   // Receive events
   wire rxStart = (state_q == ST_IDLE) & scEn & ~txStart & ~ioIn & ~lineOe_q;
   wire rxTick  = (state_q == ST_RX) & tick;
   wire rxFalse = rxTick & (bitIdx_q == BIT_START) & ioIn;
   wire rxJudge = rxTick & (bitIdx_q == BIT_ACK);
   wire rxGood  = rxJudge & ~perr_q;
   wire rxBad   = rxJudge & perr_q;
   wire rxEnd   = rxTick & (bitIdx_q == BIT_WAIT);
   wire nackRel = rxTick & (((bitIdx_q == BIT_ACK2) & ~nackTwo) | (bitIdx_q == BIT_WAIT));

   wire txLow = (bitIdx_q == BIT_START) ? 1'b1 :
                inData                  ? ~txBit :
                (bitIdx_q == BIT_PARITY) ? ~txPar : 1'b0;

   wire lineOe_d = ((state_q == ST_TX) & txLow) | nackDrv_q;

   // Flag order: retry error, overflow, tx complete, rx, rx error
   wire [4:0] flagSet = {txFail, rxGood & rxUnread_q, txOk | txFail, rxGood, rxBad};
   wire [4:0] flagClr = {5{wrInfo}} & {pwdata[INF_RTY], pwdata[INF_OVF], pwdata[INF_TXC],
                                       pwdata[INF_RX], pwdata[INF_RXERR]};
   wire [4:0] flagEn  = {cfg_q[CFG_RTY_IE], cfg_q[CFG_OVF_IE], cfg_q[CFG_TXC_IE],
                         cfg_q[CFG_RX_IE], cfg_q[CFG_RXERR_IE]};

   assign pready   = 1'b1;
   assign prdata   = prdata_q;
   assign pslverr  = pslverr_q;
   assign ioLine   = '{oe: lineOe_q, out: 1'b0};
   assign irq      = irq_q;
   assign dmaTxReq = scEn & ~retryLock_q & ~txPending_q;

   // Read data is captured in the setup phase, so every access is zero-wait
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else if (setupPh)
      begin
         prdata_q  <= pwrite ? 32'h00000000 : rdMux;
         pslverr_q <= ~mapped;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cfg_q <= CFG_RST;
      else if (wrCfg)
         cfg_q <= pwdata[CFG_W-1:0];
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         clkReg_q <= CLK_RST;
      else if (wrClk)
         clkReg_q <= pwdata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         bit_rate_divider_q <= BAUD_RST;
      else if (wrBaudLo)
         bit_rate_divider_q[7:0] <= pwdata[7:0];
      else if (wrBaudHi)
         bit_rate_divider_q[15:8] <= pwdata[7:0];
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         flags_q <= 5'h00;
      else
         flags_q <= flagSet | (flags_q & ~flagClr);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         irq_q <= 1'b0;
      else
         irq_q <= |(flags_q & flagEn);
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         baudCnt_q <= 16'h0000;
      else if (txStart)
         baudCnt_q <= bit_rate_divider_q;
      else if (rxStart)
         baudCnt_q <= midLoad;
      else if (tick)
         baudCnt_q <= bit_rate_divider_q;
      else
         baudCnt_q <= baudCnt_q + 16'h0001;
   end

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (txStart)
               state_d = ST_TX;
            else if (rxStart)
               state_d = ST_RX;
         end
         ST_TX:
         begin
            if (txOk || txFail)
               state_d = ST_IDLE;
         end
         ST_RX:
         begin
            if (rxFalse || rxEnd)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
      if (!scEn)
         state_d = ST_IDLE;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         bitIdx_q <= BIT_START;
      else if (txStart || rxStart || txRetry)
         bitIdx_q <= BIT_START;
      else if (tick && state_q != ST_IDLE)
         bitIdx_q <= bitIdx_q + 4'h1;
   end

   // One write is held per character; writes while one is pending are dropped
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         txData_q    <= 8'h00;
         txPending_q <= 1'b0;
      end
      else if (!scEn)
         txPending_q <= 1'b0;
      else if (wrData && !txPending_q)
      begin
         txData_q    <= pwdata[7:0];
         txPending_q <= 1'b1;
      end
      else if (txOk || txFail)
         txPending_q <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         retryCnt_q <= 4'h0;
      else if (txStart)
         retryCnt_q <= 4'h0;
      else if (txRetry)
         retryCnt_q <= retryCnt_q + 4'h1;
   end

   // Only a disable clears the lock, forcing software to reinitialise
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         retryLock_q <= 1'b0;
      else if (!scEn)
         retryLock_q <= 1'b0;
      else if (txFail)
         retryLock_q <= 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ack1_q <= 1'b1;
         ack2_q <= 1'b1;
      end
      else if (txTick && bitIdx_q == BIT_ACK)
         ack1_q <= ioIn;
      else if (txTick && bitIdx_q == BIT_ACK2)
         ack2_q <= ioIn;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         ackBit_q <= 1'b0;
      else if (txEnd)
         ackBit_q <= ~nack;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         parBit_q <= 1'b0;
      else if (txStart)
         parBit_q <= txPar;
      else if (rxTick && bitIdx_q == BIT_PARITY)
         parBit_q <= ioIn;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rxShift_q <= 8'h00;
      else if (rxTick && inData)
         rxShift_q[slot] <= ioIn;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         perr_q <= 1'b0;
      else if (rxTick && bitIdx_q == BIT_PARITY)
         perr_q <= ioIn ^ rxPar;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rxData_q <= 8'h00;
      else if (rxGood)
         rxData_q <= rxShift_q;
   end

   // A new character beats the read that would mark the old one consumed
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rxUnread_q <= 1'b0;
      else if (rxGood)
         rxUnread_q <= 1'b1;
      else if (rdData)
         rxUnread_q <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         nackDrv_q <= 1'b0;
      else if (!scEn || nackRel)
         nackDrv_q <= 1'b0;
      else if (rxBad && autoNack)
         nackDrv_q <= 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         lineOe_q <= 1'b0;
      else
         lineOe_q <= lineOe_d;
   end

   scd_card_clk
   #(
      .DIV_W   (CLK_DIV_W)
   )
   u_cardClk
   (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .enable  (clkReg_q[CLK_EN]),
      .divide  (clkReg_q[CLK_DIV_W-1:0]),
      .cardClk (cardClk)
   );

endmodule

// ### scd_pkg.sv
package scd_pkg;

   localparam int ADDR_W = 8;

   localparam logic [7:0] OFF_BAUD_LO = 8'h04;
   localparam logic [7:0] OFF_BAUD_HI = 8'h08;
   localparam logic [7:0] OFF_DATA    = 8'h0C;
   localparam logic [7:0] OFF_INFO    = 8'h10;
   localparam logic [7:0] OFF_CFG     = 8'h14;
   localparam logic [7:0] OFF_CLK     = 8'h18;

   localparam int CFG_W        = 17;
   localparam int CFG_EN       = 0;
   localparam int CFG_PAR      = 1;
   localparam int CFG_RXERR_IE = 2;
   localparam int CFG_NACK_LEN = 4;
   localparam int CFG_RX_IE    = 5;
   localparam int CFG_TXC_IE   = 6;
   localparam int CFG_OVF_IE   = 7;
   localparam int CFG_RTY_IE   = 8;
   localparam int CFG_AUTO     = 9;
   localparam int CFG_LSB      = 11;
   localparam int CFG_RTY_LO   = 12;
   localparam int CFG_ACK_SEL  = 16;

   localparam int INF_ACK   = 0;
   localparam int INF_PAR   = 1;
   localparam int INF_RXERR = 2;
   localparam int INF_RX    = 5;
   localparam int INF_TXC   = 6;
   localparam int INF_OVF   = 7;
   localparam int INF_RTY   = 8;

   localparam int CLK_EN    = 7;
   localparam int CLK_DIV_W = 7;

   localparam logic [CFG_W-1:0] CFG_RST  = 17'h00000;
   localparam logic [7:0]       CLK_RST  = 8'h00;
   localparam logic [15:0]      BAUD_RST = 16'h0000;

   localparam logic [15:0] BAUD_TOP   = 16'hFFFF;
   localparam logic [16:0] BAUD_SPAN  = 17'h10000;
   localparam logic [3:0]  BIT_START  = 4'h0;
   localparam logic [3:0]  BIT_DLAST  = 4'h8;
   localparam logic [3:0]  BIT_PARITY = 4'h9;
   localparam logic [3:0]  BIT_ACK    = 4'hA;
   localparam logic [3:0]  BIT_ACK2   = 4'hB;
   localparam logic [3:0]  BIT_WAIT   = 4'hC;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_TX   = 2'b01,
      ST_RX   = 2'b10
   } scd_state_t;

   typedef struct packed
   {
      logic oe;
      logic out;
   } scd_line_t;

endpackage

// ### scd_card_clk.sv
`timescale 1ns/100ps
module scd_card_clk
#(
   parameter int DIV_W = 7
)
(
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             enable,
   input  wire logic [DIV_W-1:0] divide,
   output logic                  cardClk
);
   logic [DIV_W-1:0] cnt_q;
   logic             level_q;

   wire [DIV_W:0]   ratio  = {1'b0, divide} + {{DIV_W{1'b0}}, 1'b1};
   wire [DIV_W-1:0] half   = ratio[DIV_W:1];
   wire             wrap   = cnt_q >= divide;
   wire             passUp = divide == {DIV_W{1'b0}};

   // Wrap on >= so a smaller divider written mid-run cannot stall
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= '0;
      else if (!enable || wrap)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         level_q <= 1'b0;
      else
         level_q <= enable && (cnt_q < half);
   end

   // Ratio one cannot come from a flop; the gated bus clock is passed,
   // so toggle the enable only while the divider is nonzero to avoid runts
   assign cardClk = passUp ? (enable & mclk) : level_q;

endmodule

// ### scd_checker.sv
`timescale 1ns/100ps
module scd_checker
(
   input wire logic                       mclk,
   input wire logic                       rst_b,
   input wire logic [scd_pkg::ADDR_W-1:0] paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       ioIn,
   input wire scd_pkg::scd_line_t         ioLine,
   input wire logic                       cardClk,
   input wire logic                       dmaTxReq,
   input wire logic                       irq
);
   import scd_pkg::*;
   // Interrupt enables at bits 8,7,6,5,2
   localparam logic [CFG_W-1:0] IE_MASK = 17'h001E4;
   logic [7:0]       shadowClk_q;
   logic [CFG_W-1:0] shadowCfg_q;
   logic [7:0]       gap_q;
   logic [7:0]       age_q;
   wire              busWr  = psel && penable && pwrite && pready;
   wire              mapped = paddr inside {OFF_BAUD_LO, OFF_BAUD_HI, OFF_DATA, OFF_INFO,
                                            OFF_CFG, OFF_CLK};

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shadowClk_q <= CLK_RST;
         shadowCfg_q <= CFG_RST;
      end
      else if (busWr && paddr == OFF_CLK)
         shadowClk_q <= pwdata[7:0];
      else if (busWr && paddr == OFF_CFG)
         shadowCfg_q <= pwdata[CFG_W-1:0];
   end

   // Period is judged only once the divider has been left alone for a while
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gap_q <= 8'h00;
         age_q <= 8'h00;
      end
      else
      begin
         gap_q <= $rose(cardClk) ? 8'h01 : gap_q + 8'(gap_q != 8'hFF);
         age_q <= (busWr && paddr == OFF_CLK) ? 8'h00 : age_q + 8'(age_q != 8'hFF);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_badSetup;
      psel && !penable && !mapped;
   endsequence
   property p_errFlag;
      s_badSetup |=> pslverr;
   endproperty
   a_errFlag: assert property (p_errFlag) else $error("unmapped access not refused");
   property p_readZero;
      s_badSetup ##0 !pwrite |=> prdata == 32'h00000000;
   endproperty
   a_readZero: assert property (p_readZero) else $error("unmapped read not zero");
   property p_clkOff;
      !shadowClk_q[CLK_EN] && !$past(shadowClk_q[CLK_EN]) |-> !cardClk;
   endproperty
   a_clkOff: assert property (p_clkOff) else $error("card clock while off");
   property p_clkRuns;
      age_q == 8'hFF && shadowClk_q[CLK_EN] && shadowClk_q[6:0] != 7'h00 |-> gap_q <= 8'h80;
   endproperty
   a_clkRuns: assert property (p_clkRuns) else $error("card clock stalled");
   property p_clkPeriod;
      $rose(cardClk) && age_q == 8'hFF && shadowClk_q[6:0] != 7'h00
         |-> gap_q == shadowClk_q[6:0] + 8'h01;
   endproperty
   a_clkPeriod: assert property (p_clkPeriod) else $error("card clock period");
   property p_enOff;
      !shadowCfg_q[CFG_EN] && !$past(shadowCfg_q[CFG_EN]) |-> !dmaTxReq && !ioLine.oe;
   endproperty
   a_enOff: assert property (p_enOff) else $error("activity while disabled");
   property p_irqOff;
      (shadowCfg_q & IE_MASK) == 0 && ($past(shadowCfg_q) & IE_MASK) == 0 |-> !irq;
   endproperty
   a_irqOff: assert property (p_irqOff) else $error("irq with no enable");
   property p_irqCause;
      $rose(irq) |-> ($past(shadowCfg_q) & IE_MASK) != 0;
   endproperty
   a_irqCause: assert property (p_irqCause) else $error("irq rose unmasked");
endmodule

bind scd_smartcard_uart scd_checker scd_checker_i
(
   .mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ioIn(ioIn), .ioLine(ioLine), .cardClk(cardClk), .dmaTxReq(dmaTxReq), .irq(irq)
);

// ### scd_card_model.sv
`timescale 1ns/100ps
module scd_card_model
#(
   parameter int PERIOD = 32
)
(
   input  wire logic mclk,
   input  wire logic line,
   output logic      drive
);
   int         nackLeft = 0;
   int         ackBits  = 1;
   int         frames   = 0;
   int         lowCyc   = 0;
   logic [9:0] got;
   logic       busy     = 0;

   initial drive = 0;

   always
   begin
      @(posedge mclk);
      if (!busy && !line)
      begin
         repeat (PERIOD / 2) @(posedge mclk);
         for (int i = 0; i < 10; i++)
         begin
            got[i] = line;
            repeat (PERIOD) @(posedge mclk);
         end
         if (nackLeft > 0)
         begin
            nackLeft--;
            drive <= 1;
            repeat (ackBits * PERIOD) @(posedge mclk);
            drive <= 0;
         end
         frames++;
      end
   end

   // Bits in wire order, start bit first; then watch the guard time
   task automatic send(input logic [9:0] bits);
      busy = 1;
      for (int i = 0; i < 10; i++)
      begin
         drive <= !bits[i];
         repeat (PERIOD) @(posedge mclk);
      end
      drive <= 0;
      lowCyc = 0;
      repeat (3 * PERIOD)
      begin
         @(posedge mclk);
         if (!line)
            lowCyc++;
      end
      busy = 0;
   endtask
endmodule

// ### scd_smartcard_uart_tb_top.sv
`timescale 1ns/100ps
module scd_smartcard_uart_tb_top;
   import scd_pkg::*;
   localparam int P = 32;
   logic              mclk, rst_b, psel, penable, pwrite, err, last;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, cardClk, dmaTxReq, irq, cardDrv;
   wire logic         ioIn;
   scd_line_t         ioLine;
   logic [7:0]        b;
   logic [9:0]        exp;
   int                fail_count = 0, compares = 0, seed = 86453, cyc = 0;
   int                d, k, n, f0;

   assign ioIn = !(ioLine.oe || cardDrv);

   scd_smartcard_uart scd_smartcard_uart_i
   (
      .mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ioIn(ioIn), .ioLine(ioLine), .cardClk(cardClk),
      .dmaTxReq(dmaTxReq), .irq(irq)
   );
   scd_card_model #(.PERIOD(P)) scd_card_model_i (.mclk(mclk), .line(ioIn), .drive(cardDrv));

   initial
   begin
      mclk = 0;
      forever #20 mclk = !mclk;
   end

   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
      compares++;
      if (got !== want)
      begin
         fail_count++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, want);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge mclk);
      psel    <= 1;
      penable <= 0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 0;
      penable <= 0;
   endtask

   function automatic logic [9:0] frame(input logic [7:0] v, input logic odd, input logic lsb);
      logic [9:0] f;
      f[0] = 0;
      for (int i = 0; i < 8; i++)
         f[i+1] = lsb ? v[i] : v[7-i];
      f[9] = ^v ^ odd;
      return f;
   endfunction

   // Clears status, sends one byte, waits for the given count of frames
   task automatic sendByte(input logic [7:0] v, input int nf);
      apb(OFF_INFO, 1, 32'h000001FF);
      f0 = scd_card_model_i.frames;
      apb(OFF_DATA, 1, {24'h000000, v});
      while (scd_card_model_i.frames < f0 + nf)
         @(posedge mclk);
      repeat (4 * P) @(posedge mclk);
   endtask

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rst_b = 0;
      repeat (20) @(posedge mclk);
      rst_b <= 1;
      for (int a = 4; a <= 24; a += 4)
      begin
         apb(8'(a), 0, 0);
         chk(rd, 0, "reset value");
      end
      apb(8'h20, 0, 0);
      chk({31'h0, err}, 1, "unmapped error");
      repeat (3)
      begin
         k = $random(seed) & 32'h0001FFFE | 32'h00000400;
         apb(OFF_CFG, 1, k);
         apb(OFF_CFG, 0, 0);
         chk(rd, k, "config readback");
      end
      for (int i = 0; i < 3; i++)
      begin
         d = i == 0 ? 1 : i == 2 ? 127 : 2 + {$random(seed)} % 125;
         apb(OFF_CLK, 1, 32'h80 | d);
         repeat (260) @(posedge mclk);
         k = 0;
         n = 0;
         last = 1;
         repeat (300)
         begin
            @(posedge mclk);
            n++;
            if (cardClk === 1'b1 && last === 1'b0)
            begin
               if (k)
                  chk(n, d + 1, "card clock period");
               k = 1;
               n = 0;
            end
            last = cardClk;
         end
      end
      apb(OFF_CLK, 1, 32'h0000007F);
      // Output flop lags the enable by one cycle
      @(posedge mclk);
      k = 0;
      repeat (300)
      begin
         @(posedge mclk);
         if (cardClk !== 1'b0)
            k++;
      end
      chk(k, 0, "card clock stopped");
      apb(OFF_BAUD_LO, 1, 32'h000000E0);
      apb(OFF_BAUD_HI, 1, 32'h000000FF);
      for (int m = 0; m < 4; m++)
      begin
         b   = $random(seed);
         exp = frame(b, m[0], m[1]);
         apb(OFF_CFG, 1, 32'h441 | m[0] << CFG_PAR | m[1] << CFG_LSB);
         sendByte(b, 1);
         chk(scd_card_model_i.got, exp, "tx bits");
         apb(OFF_INFO, 0, 0);
         chk(rd & 32'h143, 32'h41 | exp[9] << 1, "tx status");
         chk(dmaTxReq, 1, "dma request");
         chk(irq, 1, "tx irq");
      end
      for (int m = 0; m < 2; m++)
      begin
         scd_card_model_i.nackLeft = 3 * m + 1;
         scd_card_model_i.ackBits  = m + 1;
         apb(OFF_CFG, 1, 32'h401 | 3 * m << CFG_RTY_LO | !m << CFG_ACK_SEL | m << CFG_RTY_IE);
         sendByte($random(seed), 3 * m + 1);
         apb(OFF_DATA, 1, 32'h0000005A);
         repeat (16 * P) @(posedge mclk);
         chk(scd_card_model_i.frames - f0, 3 * m + 1, "frames sent");
         apb(OFF_INFO, 0, 0);
         chk(rd & 32'h141, 32'h140, "retry status");
         chk(dmaTxReq, 0, "dma held off");
         chk(irq, m, "retry irq");
         apb(OFF_INFO, 1, 32'h000001FF);
         apb(OFF_CFG, 1, 0);
         chk(irq, 0, "irq cleared");
      end
      for (int m = 0; m < 4; m++)
      begin
         b   = $random(seed);
         exp = frame(b, m[0], m[0]);
         exp[9] = exp[9] ^ (m != 0);
         apb(OFF_INFO, 1, 32'h000001FF);
         apb(OFF_CFG, 1, 32'h421 | m[0] << CFG_PAR | m[0] << CFG_LSB | (m > 1) << CFG_AUTO
             | (m == 3) << CFG_NACK_LEN);
         scd_card_model_i.send(exp);
         chk(scd_card_model_i.lowCyc, m > 1 ? (m - 1) * P : 0, "nack low");
         apb(OFF_INFO, 0, 0);
         chk(rd & 32'h24, m ? 32'h4 : 32'h20, "rx status");
         chk(irq, m == 0, "rx irq");
         apb(OFF_DATA, 0, 0);
         if (m == 0)
            chk(rd, b, "rx data");
      end
      // Two good characters with no read between them
      apb(OFF_INFO, 1, 32'h000001FF);
      apb(OFF_CFG, 1, 32'h00000481);
      repeat (2)
         scd_card_model_i.send(frame(b, 0, 0));
      apb(OFF_INFO, 0, 0);
      chk(rd & 32'hA4, 32'hA0, "rx overflow");
      chk(irq, 1, "overflow irq");
      apb(OFF_DATA, 0, 0);
      chk(rd, b, "rx data kept");
      stop_test();
   end
endmodule
